// File: core/booth_mul.v
// Purpose: iterative 2-bit Booth multiply-accumulate, low 32 product bits
// Assumes: operands held stable by this module once started
// Notes:   step count follows the significant width of the multiplier
`timescale 1ns/1ns
`default_nettype none
`include "psr_mul_consts.vh"

module booth_mul #(
  parameter WIDTH = 32
) (
  // clock and reset
  input  wire             clk,
  input  wire             arst_n,
  // start with operands
  input  wire             start,
  input  wire [WIDTH-1:0] mcand,
  input  wire [WIDTH-1:0] mplier,
  input  wire [WIDTH-1:0] addend,
  // progress and result
  output reg              busy_q,
  output wire             last,
  output wire [WIDTH-1:0] sum_next
);

  reg [WIDTH-1:0] acc_q;
  reg [WIDTH-1:0] a_q;
  reg [WIDTH-1:0] b_q;
  reg             prev_q;
  reg [4:0]       cnt_q;

  // number of booth digits needed: 1 for 0/1, capped at 16
  function [4:0] steps_for;
    input [WIDTH-1:0] b;
    integer k;
    integer t;
    begin
      steps_for = 5'h01;
      for (k = 1; k < WIDTH; k = k + 1) begin
        t = k + 3;
        if (b[k]) begin
          steps_for = (k >= `MUL_CAP_BIT) ? `MUL_MAX_STEPS : t[5:1];
        end
      end
    end
  endfunction

  // partial product for one recoded digit
  function [WIDTH-1:0] booth_term;
    input [2:0]       sel;
    input [WIDTH-1:0] a;
    begin
      case (sel)
        3'h1, 3'h2: booth_term = a;
        3'h3:       booth_term = {a[WIDTH-2:0], 1'b0};
        3'h4:       booth_term = ~{a[WIDTH-2:0], 1'b0} + 1'b1;
        3'h5, 3'h6: booth_term = ~a + 1'b1;
        default:    booth_term = {WIDTH{1'b0}};
      endcase
    end
  endfunction

  assign sum_next = acc_q + booth_term({b_q[1:0], prev_q}, a_q);
  assign last     = busy_q && (cnt_q == 5'h01);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      acc_q  <= {WIDTH{1'b0}};
      a_q    <= {WIDTH{1'b0}};
      b_q    <= {WIDTH{1'b0}};
      prev_q <= 1'b0;
      cnt_q  <= 5'h00;
    end else if (start) begin
      busy_q <= 1'b1;
      acc_q  <= addend;
      a_q    <= mcand;
      b_q    <= mplier;
      prev_q <= 1'b0;
      cnt_q  <= steps_for(mplier);
    end else if (busy_q) begin
      acc_q  <= sum_next;
      a_q    <= {a_q[WIDTH-3:0], 2'h0};
      b_q    <= {2'h0, b_q[WIDTH-1:2]};
      prev_q <= b_q[1];
      cnt_q  <= cnt_q - 5'h01;
      busy_q <= !last;
    end
  end

endmodule
`default_nettype wire

// File: core/psr_mul_consts.vh
// Purpose: shared constants of the status-transfer and multiply unit
// Assumes: 32-bit instruction word, status word bits laid out N Z C V at top
// Notes:   definitions only
`ifndef PSR_MUL_CONSTS_VH
`define PSR_MUL_CONSTS_VH

// status word layout
`define ST_RESET_VAL     32'h0000_00D3
`define ST_DEFINED_MASK  32'hF000_00DF
`define ST_FLAGS_MASK    32'hF000_0000
`define ST_ZERO          32'h0000_0000
`define ST_FLAGS         31:28
`define ST_MODE          4:0
`define ST_N             31
`define ST_Z             30
`define ST_C             29
`define ST_V             28

// mode encodings
`define MODE_USR         5'h10
`define MODE_FIQ         5'h11
`define MODE_IRQ         5'h12
`define MODE_SVC         5'h13
`define MODE_ABT         5'h17
`define MODE_UND         5'h1B

// saved status bank slots
`define BANK_FIQ         3'h0
`define BANK_IRQ         3'h1
`define BANK_SVC         3'h2
`define BANK_ABT         3'h3
`define BANK_UND         3'h4
`define BANK_WORDS       5

// instruction fields
`define F_COND           31:28
`define F_CLASS          27:26
`define F_PSR_OP         24:23
`define F_MUL_OP         27:22
`define F_MUL_TAG        7:4
`define F_RN             19:16
`define F_RD             15:12
`define F_RM             3:0
`define F_ACC_RN         15:12
`define F_MUL_RD         19:16
`define B_IMM            25
`define B_PSR_SEL        22
`define B_MSR            21
`define B_ACC            21
`define B_SFLAG          20
`define B_FULL           16
`define B_REGSHIFT       4
`define CLASS_DP         2'h0
`define PSR_OP_VAL       2'h2
`define MUL_OP_VAL       6'h00
`define MUL_TAG_VAL      4'h9
`define REG_PC           4'hF

// cycle type codes
`define CYC_NONE         2'h0
`define CYC_SEQ          2'h1
`define CYC_NONSEQ       2'h2
`define CYC_INT          2'h3

// multiply step bounds
`define MUL_MAX_STEPS    5'h10
`define MUL_CAP_BIT      29

`endif

// File: core/psr_mul_unit.v
// Purpose: executes status transfers, multiplies and pc-writing data ops
// Assumes: register file, alu and shifter outside; operands come with instr
// Notes:   one instruction at a time; effects land at the done pulse, except pc writes and their status restore, which land cycles before it
`timescale 1ns/1ns
`default_nettype none
`include "psr_mul_consts.vh"

module psr_mul_unit (
  // clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // instruction issue
  input  wire        instr_valid,
  input  wire [31:0] instr,
  output reg         instr_ready_q,
  // operand values read for this instruction
  input  wire [31:0] rm_value,
  input  wire [31:0] rs_value,
  input  wire [31:0] rn_value,
  input  wire [31:0] imm_value,
  input  wire [31:0] alu_result,
  // general register write
  output reg         rf_wr_en_q,
  output reg  [3:0]  rf_wr_idx_q,
  output reg  [31:0] rf_wr_data_q,
  // program counter write
  output reg         pc_wr_en_q,
  output reg  [31:0] pc_wr_data_q,
  // status and timing
  output reg  [31:0] current_status_word_q,
  output reg  [1:0]  cycle_type_q,
  output reg         instr_done_q
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_EXEC = 3'h1;
  localparam [2:0] ST_MUL  = 3'h2;
  localparam [2:0] ST_INT  = 3'h3;
  localparam [2:0] ST_PCN  = 3'h4;
  localparam [2:0] ST_PCS  = 3'h5;

  reg  [2:0]  state_q;
  reg  [31:0] instr_q;
  reg  [31:0] rm_q;
  reg  [31:0] rs_q;
  reg  [31:0] rn_q;
  reg  [31:0] imm_q;
  reg  [31:0] alu_q;
  reg         mul_set_flags_q;
  reg  [3:0]  mul_rd_q;
  reg  [31:0] cur_d;
  reg         bank_wr_en;
  reg  [31:0] status_src;
  reg  [31:0] status_mask;
  wire [31:0] saved_rd;
  wire        mul_busy;
  wire        mul_last;
  wire [31:0] mul_sum;

  // condition field test against current flags
  function cond_pass;
    input [3:0] c;
    input [3:0] f;
    reg n;
    reg z;
    reg cy;
    reg v;
    begin
      n  = f[3];
      z  = f[2];
      cy = f[1];
      v  = f[0];
      case (c)
        4'h0:    cond_pass = z;
        4'h1:    cond_pass = !z;
        4'h2:    cond_pass = cy;
        4'h3:    cond_pass = !cy;
        4'h4:    cond_pass = n;
        4'h5:    cond_pass = !n;
        4'h6:    cond_pass = v;
        4'h7:    cond_pass = !v;
        4'h8:    cond_pass = cy && !z;
        4'h9:    cond_pass = !cy || z;
        4'hA:    cond_pass = (n == v);
        4'hB:    cond_pass = (n != v);
        4'hC:    cond_pass = !z && (n == v);
        4'hD:    cond_pass = z || (n != v);
        4'hE:    cond_pass = 1'b1;
        default: cond_pass = 1'b0;
      endcase
    end
  endfunction

  // bank slot of a mode; user and unknown modes have none
  function [3:0] bank_of;
    input [4:0] mode;
    begin
      case (mode)
        `MODE_FIQ: bank_of = {1'b1, `BANK_FIQ};
        `MODE_IRQ: bank_of = {1'b1, `BANK_IRQ};
        `MODE_SVC: bank_of = {1'b1, `BANK_SVC};
        `MODE_ABT: bank_of = {1'b1, `BANK_ABT};
        `MODE_UND: bank_of = {1'b1, `BANK_UND};
        default:   bank_of = 4'h0;
      endcase
    end
  endfunction

  // replace masked defined bits, reserved bits forced to zero
  function [31:0] status_merge;
    input [31:0] old;
    input [31:0] src;
    input [31:0] mask;
    begin
      status_merge = ((old & ~mask) | (src & mask)) & `ST_DEFINED_MASK;
    end
  endfunction

  wire [3:0] bank_sel   = bank_of(current_status_word_q[`ST_MODE]);
  wire       have_saved = bank_sel[3];
  wire       user_mode  = current_status_word_q[`ST_MODE] == `MODE_USR;
  wire       cond_ok    = cond_pass(instr_q[`F_COND],
                                    current_status_word_q[`ST_FLAGS]);

  // decode of the held instruction
  wire is_dp   = instr_q[`F_CLASS] == `CLASS_DP;
  wire is_mul  = (instr_q[`F_MUL_OP] == `MUL_OP_VAL) &&
                 (instr_q[`F_MUL_TAG] == `MUL_TAG_VAL);
  wire is_psr  = is_dp && !is_mul &&
                 (instr_q[`F_PSR_OP] == `PSR_OP_VAL) &&
                 !instr_q[`B_SFLAG];
  wire is_msr  = is_psr && instr_q[`B_MSR];
  wire to_saved_status_word = instr_q[`B_PSR_SEL];
  wire is_pcw  = is_dp && !is_mul && !is_psr &&
                 (instr_q[`F_RD] == `REG_PC);
  wire reg_sh  = !instr_q[`B_IMM] && instr_q[`B_REGSHIFT];
  wire mul_go  = (state_q == ST_EXEC) && is_mul && cond_ok;

  // operand overlap: the destination overwrites the first multiplicand
  wire        rd_is_rm  = instr_q[`F_MUL_RD] == instr_q[`F_RM];
  wire [31:0] mul_cand  = rd_is_rm ? `ST_ZERO : rm_q;
  wire [31:0] mul_add   = instr_q[`B_ACC] ? rn_q : `ST_ZERO;

  saved_status_bank #(
    .WORDS(`BANK_WORDS)
  ) u_bank (
    .clk      (clk),
    .arst_n   (arst_n),
    .wr_en    (bank_wr_en),
    .wr_idx   (bank_sel[2:0]),
    .wr_data  (status_merge(saved_rd, status_src, status_mask)),
    .rd_idx   (bank_sel[2:0]),
    .rd_data_q(saved_rd)
  );

  // operands latched at start; an rd equal to rm still gives a zero multiplicand
  booth_mul #(
    .WIDTH(32)
  ) u_mul (
    .clk     (clk),
    .arst_n  (arst_n),
    .start   (mul_go),
    .mcand   (mul_cand),
    .mplier  (rs_q),
    .addend  (mul_add),
    .busy_q  (mul_busy),
    .last    (mul_last),
    .sum_next(mul_sum)
  );

  // status write source, mask and targets
  always @* begin
    status_src  = (instr_q[`B_IMM] && !instr_q[`B_FULL]) ? imm_q : rm_q;
    status_mask = `ST_DEFINED_MASK;
    if (!instr_q[`B_FULL]) begin
      status_mask = `ST_FLAGS_MASK;
    end else if (!to_saved_status_word && user_mode) begin
      status_mask = `ST_FLAGS_MASK;
    end
    cur_d      = current_status_word_q;
    bank_wr_en = 1'b0;
    if (state_q == ST_EXEC && cond_ok) begin
      if (is_msr && !to_saved_status_word) begin
        cur_d = status_merge(current_status_word_q, status_src,
                             status_mask);
      end else if (is_msr && to_saved_status_word) begin
        bank_wr_en = have_saved;
      end else if (is_pcw && instr_q[`B_SFLAG] && have_saved) begin
        cur_d = saved_rd & `ST_DEFINED_MASK;
      end
    end
    if (state_q == ST_MUL && mul_last && mul_set_flags_q) begin
      cur_d[`ST_N] = mul_sum[31];
      cur_d[`ST_Z] = (mul_sum == `ST_ZERO);
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q               <= ST_IDLE;
      instr_q               <= `ST_ZERO;
      rm_q                  <= `ST_ZERO;
      rs_q                  <= `ST_ZERO;
      rn_q                  <= `ST_ZERO;
      imm_q                 <= `ST_ZERO;
      alu_q                 <= `ST_ZERO;
      mul_set_flags_q       <= 1'b0;
      mul_rd_q              <= 4'h0;
      instr_ready_q         <= 1'b1;
      rf_wr_en_q            <= 1'b0;
      rf_wr_idx_q           <= 4'h0;
      rf_wr_data_q          <= `ST_ZERO;
      pc_wr_en_q            <= 1'b0;
      pc_wr_data_q          <= `ST_ZERO;
      current_status_word_q <= `ST_RESET_VAL;
      cycle_type_q          <= `CYC_NONE;
      instr_done_q          <= 1'b0;
    end else begin
      current_status_word_q <= cur_d;
      rf_wr_en_q            <= 1'b0;
      pc_wr_en_q            <= 1'b0;
      instr_done_q          <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (instr_valid) begin
            instr_q       <= instr;
            rm_q          <= rm_value;
            rs_q          <= rs_value;
            rn_q          <= rn_value;
            imm_q         <= imm_value;
            alu_q         <= alu_result;
            instr_ready_q <= 1'b0;
            cycle_type_q  <= `CYC_SEQ;
            state_q       <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (mul_go) begin
            mul_set_flags_q <= instr_q[`B_SFLAG];
            mul_rd_q        <= instr_q[`F_MUL_RD];
            cycle_type_q    <= `CYC_INT;
            state_q         <= ST_MUL;
          end else if (is_pcw && cond_ok) begin
            pc_wr_en_q   <= 1'b1;
            pc_wr_data_q <= alu_q;
            if (reg_sh) begin
              cycle_type_q <= `CYC_INT;
              state_q      <= ST_INT;
            end else begin
              cycle_type_q <= `CYC_NONSEQ;
              state_q      <= ST_PCN;
            end
          end else begin
            if (is_psr && !is_msr && cond_ok) begin
              rf_wr_en_q   <= 1'b1;
              rf_wr_idx_q  <= instr_q[`F_RD];
              rf_wr_data_q <= to_saved_status_word ?
                              (have_saved ? saved_rd : `ST_ZERO) :
                              current_status_word_q;
            end
            instr_done_q  <= 1'b1;
            instr_ready_q <= 1'b1;
            cycle_type_q  <= `CYC_NONE;
            state_q       <= ST_IDLE;
          end
        end
        ST_MUL: begin
          if (mul_last || !mul_busy) begin
            rf_wr_en_q    <= 1'b1;
            rf_wr_idx_q   <= mul_rd_q;
            rf_wr_data_q  <= mul_sum;
            instr_done_q  <= 1'b1;
            instr_ready_q <= 1'b1;
            cycle_type_q  <= `CYC_NONE;
            state_q       <= ST_IDLE;
          end
        end
        ST_INT: begin
          cycle_type_q <= `CYC_NONSEQ;
          state_q      <= ST_PCN;
        end
        ST_PCN: begin
          cycle_type_q <= `CYC_SEQ;
          state_q      <= ST_PCS;
        end
        ST_PCS: begin
          instr_done_q  <= 1'b1;
          instr_ready_q <= 1'b1;
          cycle_type_q  <= `CYC_NONE;
          state_q       <= ST_IDLE;
        end
        default: begin
          instr_ready_q <= 1'b1;
          cycle_type_q  <= `CYC_NONE;
          state_q       <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// File: core/saved_status_bank.v
// Purpose: banked saved status words, one per privileged exception mode
// Assumes: single clock, read data registered
// Notes:   reserved bits are never stored
`timescale 1ns/1ns
`default_nettype none
`include "psr_mul_consts.vh"

module saved_status_bank #(
  parameter WORDS = `BANK_WORDS
) (
  // clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // write port
  input  wire        wr_en,
  input  wire [2:0]  wr_idx,
  input  wire [31:0] wr_data,
  // registered read port
  input  wire [2:0]  rd_idx,
  output reg  [31:0] rd_data_q
);

  reg [31:0] mem_q [0:WORDS-1];
  integer    i;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < WORDS; i = i + 1) begin
        mem_q[i] <= `ST_ZERO;
      end
      rd_data_q <= `ST_ZERO;
    end else begin
      if (wr_en) begin
        mem_q[wr_idx] <= wr_data & `ST_DEFINED_MASK;
      end
      rd_data_q <= mem_q[rd_idx];
    end
  end

endmodule
`default_nettype wire

// File: test/psr_mul_sva.sv
// Purpose: port-level timing and status checks of psr_mul_unit
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every instance of psr_mul_unit
`timescale 1ns/1ns
`default_nettype none
`include "psr_mul_consts.vh"
module psr_mul_sva (
  // clock and reset
  input wire        clk,
  input wire        arst_n,
  // issue and operands
  input wire        instr_valid,
  input wire [31:0] instr,
  input wire        instr_ready_q,
  input wire [31:0] rm_value,
  input wire [31:0] rs_value,
  input wire [31:0] imm_value,
  input wire [31:0] alu_result,
  // results
  input wire [31:0] rf_wr_data_q,
  input wire        pc_wr_en_q,
  input wire [31:0] pc_wr_data_q,
  input wire [31:0] current_status_word_q,
  input wire [1:0]  cycle_type_q,
  input wire        instr_done_q
);
  wire       take = instr_valid && instr_ready_q;
  wire       al = instr[`F_COND] == 4'hE;
  wire       is_mul = instr[`F_MUL_OP] == `MUL_OP_VAL
                      && instr[`F_MUL_TAG] == `MUL_TAG_VAL;
  wire       is_psr = instr[`F_CLASS] == `CLASS_DP
                      && instr[`F_PSR_OP] == `PSR_OP_VAL && !instr[`B_SFLAG];
  wire       pc_op = al && !is_mul && !is_psr
                     && instr[`F_CLASS] == `CLASS_DP && instr[`F_RD] == `REG_PC;
  wire       rsh = !instr[`B_IMM] && instr[`B_REGSHIFT];
  wire [3:0] src_fl = instr[`B_IMM] ? imm_value[31:28] : rm_value[31:28];
  reg        mul_s_q;
  // remembers a flag-setting multiply in flight
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mul_s_q <= 1'b0;
    end else if (take) begin
      mul_s_q <= is_mul && al && instr[`B_SFLAG];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_reserved_bits_zero: assert property (
    (current_status_word_q & ~`ST_DEFINED_MASK) == `ST_ZERO)
    else $error("reserved status bits not zero");
  a_status_one_cycle: assert property (
    take && is_psr |=> cycle_type_q == `CYC_SEQ ##1 instr_done_q)
    else $error("status transfer length wrong");
  a_mul_small_rs: assert property (
    take && is_mul && al && rs_value <= 32'h0000_0001
    |=> cycle_type_q == `CYC_SEQ ##1 cycle_type_q == `CYC_INT ##1 instr_done_q)
    else $error("short multiply length wrong");
  a_mul_max_steps: assert property (
    take && is_mul && al |=> !instr_done_q [*2] ##[1:16] instr_done_q)
    else $error("multiply length out of range");
  a_pc_write_time: assert property (
    take && pc_op && !rsh |-> ##2 pc_wr_en_q && cycle_type_q == `CYC_NONSEQ
    && pc_wr_data_q == $past(alu_result, 2) ##2 instr_done_q)
    else $error("pc write timing wrong");
  a_regshift_time: assert property (
    take && pc_op && rsh |=> cycle_type_q == `CYC_SEQ
    ##1 cycle_type_q == `CYC_INT ##1 cycle_type_q == `CYC_NONSEQ
    ##2 instr_done_q)
    else $error("register shift pc write timing wrong");
  a_user_ctrl_kept: assert property (
    current_status_word_q[`ST_MODE] == `MODE_USR
    |=> $stable(current_status_word_q[7:0]))
    else $error("control bits changed in user mode");
  a_flags_only_write: assert property (
    take && is_psr && al && instr[`B_MSR] && !instr[`B_FULL]
    && !instr[`B_PSR_SEL] |-> ##2
    current_status_word_q[27:0] == $past(current_status_word_q[27:0], 2)
    && current_status_word_q[`ST_FLAGS] == $past(src_fl, 2))
    else $error("flag-only write wrong");
  a_mul_flag_set: assert property (
    mul_s_q && instr_done_q |-> current_status_word_q[`ST_N] == rf_wr_data_q[31]
    && current_status_word_q[`ST_Z] == (rf_wr_data_q == `ST_ZERO))
    else $error("multiply flags wrong");
endmodule
bind psr_mul_unit psr_mul_sva u_sva (
  .clk(clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr(instr),
  .instr_ready_q(instr_ready_q), .rm_value(rm_value), .rs_value(rs_value),
  .imm_value(imm_value), .alu_result(alu_result),
  .rf_wr_data_q(rf_wr_data_q), .pc_wr_en_q(pc_wr_en_q),
  .pc_wr_data_q(pc_wr_data_q), .current_status_word_q(current_status_word_q),
  .cycle_type_q(cycle_type_q), .instr_done_q(instr_done_q));
`default_nettype wire

// File: test/tb.sv
// Purpose: self-checking bench of psr_mul_unit
// Assumes: one instruction at a time, inputs driven 1 ns after the edge
// Notes:   user mode comes last and is left by reset only
`timescale 1ns/1ns
`default_nettype none
`include "psr_mul_consts.vh"
module tb;
  logic        clk, arst_n, instr_valid;
  logic [31:0] instr, rm_value, rs_value, rn_value, imm_value, alu_result;
  wire         instr_ready_q, rf_wr_en_q, pc_wr_en_q, instr_done_q;
  wire  [3:0]  rf_wr_idx_q;
  wire  [31:0] rf_wr_data_q, pc_wr_data_q, current_status_word_q;
  wire  [1:0]  cycle_type_q;
  int          err_count, n_tests, cyc;
  logic        wr_seen, pc_seen;
  logic [3:0]  wr_idx;
  logic [31:0] wr_data, st, sv, a, b, c, e;
  logic [1:0]  f;
  logic [31:0] corner [5] = '{32'h0, 32'h1, 32'hFFFF_FFFF, 32'h2000_0000, 32'h7};
  psr_mul_unit u_dut (
    .clk(clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr(instr),
    .instr_ready_q(instr_ready_q), .rm_value(rm_value), .rs_value(rs_value),
    .rn_value(rn_value), .imm_value(imm_value), .alu_result(alu_result),
    .rf_wr_en_q(rf_wr_en_q), .rf_wr_idx_q(rf_wr_idx_q),
    .rf_wr_data_q(rf_wr_data_q), .pc_wr_en_q(pc_wr_en_q),
    .pc_wr_data_q(pc_wr_data_q), .current_status_word_q(current_status_word_q),
    .cycle_type_q(cycle_type_q), .instr_done_q(instr_done_q));
  always #5 clk = ~clk;
  function automatic logic [31:0] status_read_instr(input logic s, input logic [3:0] d);
    return {4'hE, 5'b00010, s, 2'b00, 4'hF, d, 12'h000};
  endfunction
  function automatic logic [31:0] status_write_instr(input logic s, input logic full,
                                      input logic im, input logic [3:0] m);
    return {4'hE, 2'b00, im, 2'b10, s, 2'b10, 3'b100, full, 12'hF00, m};
  endfunction
  function automatic logic [31:0] mul(input logic [3:0] cd, input logic acc,
    input logic s, input logic [3:0] d, input logic [3:0] n,
    input logic [3:0] rs, input logic [3:0] m);
    return {cd, 6'h00, acc, s, d, n, rs, 4'h9, m};
  endfunction
  // booth step count from the highest set multiplier bit
  function automatic int steps(input logic [31:0] r);
    int p;
    p = 0;
    for (int j = 0; j < 32; j++) if (r[j]) p = j;
    if (r <= 32'h1) return 1;
    if (p >= 29) return 16;
    return (p + 3) / 2;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // offer one instruction, wait for its done pulse, keep its results
  task automatic run(input logic [31:0] i, m, s, n, im);
    int k;
    instr = i;
    rm_value = m;
    rs_value = s;
    rn_value = n;
    imm_value = im;
    alu_result = $urandom();
    instr_valid = 1'b1;
    pc_seen = 1'b0;
    k = 0;
    // ready is read between edges, where it has settled
    while (instr_ready_q !== 1'b1 && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    @(posedge clk);
    #1;
    instr_valid = 1'b0;
    instr = $urandom();
    // done shows after an edge and is sampled 1 ns after that same edge
    cyc = 1;
    do begin
      @(posedge clk);
      #1;
      cyc++;
      if (pc_wr_en_q === 1'b1) pc_seen = 1'b1;
    end while (instr_done_q !== 1'b1 && cyc < 40);
    if (k >= 40 || cyc >= 40) begin
      err_count++;
      print_verdict();
    end
    wr_seen = rf_wr_en_q;
    wr_data = rf_wr_data_q;
    wr_idx = rf_wr_idx_q;
  endtask
  initial begin
    {clk, arst_n, instr_valid} = 3'b000;
    {instr, rm_value, rs_value, rn_value, imm_value, alu_result} = '0;
    err_count = 0;
    n_tests = 0;
    void'($urandom(32'h2ae56dd9));
    repeat (12) @(posedge clk);
    #1;
    arst_n = 1'b1;
    st = `ST_RESET_VAL;
    run(status_read_instr(0, 4'h1), $urandom(), 0, 0, 0);
    chk(wr_data, st);
    chk({wr_seen, wr_idx}, 5'h11);
    chk(cyc, 2);
    run(status_write_instr(0, 0, 1, 4'h0), $urandom(), 0, 0, 32'h5000_0000);
    st = 32'h5000_00D3;
    chk(current_status_word_q, st);
    a = $urandom();
    run(status_write_instr(0, 0, 0, 4'h2), a, 0, 0, ~a);
    st[31:28] = a[31:28];
    chk(current_status_word_q, st);
    a = $urandom();
    run(status_write_instr(1, 1, 0, 4'h3), a, 0, 0, 0);
    sv = a & `ST_DEFINED_MASK;
    run(status_read_instr(1, 4'h4), 0, 0, 0, 0);
    chk(wr_data, sv);
    run(status_write_instr(1, 0, 1, 4'h0), 0, 0, 0, 32'hC000_0000);
    sv[31:28] = 4'hC;
    run(status_read_instr(1, 4'h4), 0, 0, 0, 0);
    chk(wr_data, sv);
    a = ($urandom() & 32'hFFFF_FF00) | 32'h0000_00F1;
    run(status_write_instr(0, 1, 0, 4'h5), a, 0, 0, 0);
    st = a & `ST_DEFINED_MASK;
    chk(current_status_word_q, st);
    run(status_read_instr(1, 4'h6), 0, 0, 0, 0);
    chk(wr_data, 32'h0);
    run(status_write_instr(1, 1, 0, 4'h6), 32'h2000_0011, 0, 0, 0);
    run(status_read_instr(1, 4'h6), 0, 0, 0, 0);
    chk(wr_data, 32'h2000_0011);
    run(status_write_instr(0, 1, 0, 4'h7), `ST_RESET_VAL, 0, 0, 0);
    st = `ST_RESET_VAL;
    run(status_read_instr(1, 4'h6), 0, 0, 0, 0);
    chk(wr_data, sv);
    run(status_write_instr(0, 1, 0, 4'h1) ^ 32'h1000_0000, 32'h0000_0010, 0, 0, 0);
    chk(current_status_word_q, st);
    run(mul(4'hF, 0, 1, 4'h1, 4'h4, 4'h3, 4'h2), 32'h3, 32'h5, 0, 0);
    chk(wr_seen, 1'b0);
    chk(current_status_word_q, st);
    run(status_write_instr(1, 1, 0, 4'h1), 32'h6000_00D3, 0, 0, 0);
    run(32'hE1B0_F00E, 0, 0, 0, 0);
    chk(pc_seen, 1'b1);
    chk(pc_wr_data_q, alu_result);
    chk(cyc, 4);
    st = 32'h6000_00D3;
    chk(current_status_word_q, st);
    run(32'hE1A0_F011, 0, 0, 0, 0);
    chk(pc_seen, 1'b1);
    chk(pc_wr_data_q, alu_result);
    chk(cyc, 5);
    for (int n = 0; n < 24; n++) begin
      a = (n == 4) ? 32'hFFFF_FFFD : $urandom();
      b = (n < 5) ? corner[n] : $urandom() >> $urandom_range(31, 0);
      c = $urandom();
      f = $urandom_range(3, 0);
      run(mul(4'hE, f[1], f[0], 4'h1, 4'h4, 4'h3, 4'h2), a, b, c, 0);
      e = f[1] ? a * b + c : a * b;
      chk(wr_data, e);
      chk(wr_idx, 4'h1);
      chk(cyc, 2 + steps(b));
      if (f[0]) st[31:30] = {e[31], e == 32'h0};
      chk(current_status_word_q, st);
    end
    run(mul(4'hE, 0, 0, 4'h2, 4'h4, 4'h3, 4'h2), a, b, c, 0);
    chk(wr_data, 32'h0);
    run(mul(4'hE, 1, 0, 4'h5, 4'h5, 4'h5, 4'h2), a, b, b, 0);
    chk(wr_data, a * b + b);
    run(status_write_instr(0, 1, 0, 4'h1), 32'h0000_0010, 0, 0, 0);
    run(status_write_instr(0, 1, 0, 4'h1), 32'hA000_00D3, 0, 0, 0);
    chk(current_status_word_q, 32'hA000_0010);
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    chk(current_status_word_q, `ST_RESET_VAL);
    print_verdict();
  end
endmodule
`default_nettype wire
